/* File: logic/seu_defs.svh */
/*
  constants of the standard event status unit: field positions, reset
  values, command codes, slot layout and the factory instrument state.
  assumes it is included by the package, the design modules and the bench.
*/
`ifndef SEU_DEFS_SVH
`define SEU_DEFS_SVH

// ----------------------------------------------------------------------
// event latch layout
// ----------------------------------------------------------------------
`define SEU_EV_OPC 0
`define SEU_EV_QUERY 2
`define SEU_EV_DEVICE 3
`define SEU_EV_EXEC 4
`define SEU_EV_CMD 5
`define SEU_EV_PON 7
`define SEU_EV_USED 8'hBD
`define SEU_EV_RESET 8'h80
`define SEU_MASK_RESET 8'h00
`define SEU_PSC_RESET 1'b1
`define SEU_STB_ESB 5

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define SEU_CMD_NONE 4'h0
`define SEU_CMD_CLS 4'h1
`define SEU_CMD_ESE 4'h2
`define SEU_CMD_ESE_Q 4'h3
`define SEU_CMD_ESR_Q 4'h4
`define SEU_CMD_IDN_Q 4'h5
`define SEU_CMD_OPC 4'h6
`define SEU_CMD_OPC_Q 4'h7
`define SEU_CMD_PSC 4'h8
`define SEU_CMD_PSC_Q 4'h9
`define SEU_CMD_RCL 4'hA
`define SEU_CMD_SAV 4'hB
`define SEU_CMD_RST 4'hC

// ----------------------------------------------------------------------
// state slots and answers
// ----------------------------------------------------------------------
`define SEU_SLOTS 17
`define SEU_SLOT_W 5
`define SEU_SLOT_MAX 8'h10
`define SEU_SLOT_POWER 5'h00
`define SEU_STATE_W 16
`define SEU_FACTORY_STATE 16'h0000
`define SEU_OPC_ONE 8'h01

`endif

/* File: logic/seu_pkg.sv */
/*
  types of the standard event status unit: command code, request,
  answer, state load and identification carriers.
  assumes seu_defs.svh is reachable by bare name.
*/
`include "seu_defs.svh"

package seu_pkg;

  // common command codes
  typedef enum logic [3:0] {
    SEU_NONE = `SEU_CMD_NONE,
    SEU_CLS = `SEU_CMD_CLS,
    SEU_ESE = `SEU_CMD_ESE,
    SEU_ESE_Q = `SEU_CMD_ESE_Q,
    SEU_ESR_Q = `SEU_CMD_ESR_Q,
    SEU_IDN_Q = `SEU_CMD_IDN_Q,
    SEU_OPC = `SEU_CMD_OPC,
    SEU_OPC_Q = `SEU_CMD_OPC_Q,
    SEU_PSC = `SEU_CMD_PSC,
    SEU_PSC_Q = `SEU_CMD_PSC_Q,
    SEU_RCL = `SEU_CMD_RCL,
    SEU_SAV = `SEU_CMD_SAV,
    SEU_RST = `SEU_CMD_RST
  } seu_cmd_t;

  typedef struct packed {
    logic valid;
    seu_cmd_t code;
    logic [7:0] arg;
  } seu_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } seu_resp_t;

  typedef struct packed {
    logic valid;
    logic [`SEU_STATE_W-1:0] state;
  } seu_load_t;

  // identification fields in answer order
  typedef struct packed {
    logic [15:0] maker;
    logic [15:0] model;
    logic [31:0] serial;
    logic [15:0] rev_iface;
    logic [15:0] rev_meas;
    logic [15:0] rev_source;
  } seu_idn_t;

endpackage

/* File: logic/seu_slot_mem.sv */
/*
  state slot memory: one write port, one read port with registered data.
  assumes a single clock; the array has no reset so contents outlive
  every command and reset of the surrounding logic.
*/
`timescale 1ns/1ps
`include "seu_defs.svh"

module seu_slot_mem (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [`SEU_SLOT_W-1:0] wr_addr_i,
  input wire logic [`SEU_STATE_W-1:0] wr_data_i,
  input wire logic [`SEU_SLOT_W-1:0] rd_addr_i,
  output logic [`SEU_STATE_W-1:0] rd_data_o
);

  logic [`SEU_STATE_W-1:0] mem [`SEU_SLOTS];

  // ----------------------------------------------------------------------
  // storage, kept until overwritten
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= `SEU_FACTORY_STATE;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

/* File: logic/seu_core.sv */
/*
  standard event status unit: event latch, enable mask, status byte
  summary, clear status, operation complete, power-on status clear,
  identification and recall/save of instrument state slots.
  assumes a parser that presents one decoded command per cycle on the
  clock_i domain, event pulses from the same domain, and two power pins
  from outside that are synchronised here.
*/
`timescale 1ns/1ps
`include "seu_defs.svh"

// Functional notes
// - clear status zeroes all event latches and empties the error queue.
// - clear status also drops latched overvoltage and overcurrent trips.
// - enabled event bits are reported on status byte bit 5.
// - layout: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power-on.
// - enable mask query returns the mask value.
// - host writes mask 0 to 255; mask defaults to zero.
// - mask is writable, readable and survives clear status.
// - events latch unbuffered; repeats on a set bit are ignored.
// - event latch is read-only and clears when read.
// - event query returns the latch value.
// - after opc command, bit 0 sets when the current operation ends.
// - opc query answers one only once the current operation ends.
// - power-on clear setting: 1 zeroes enable masks at power-on.
// - the setting never changes how event or condition bits clear.
// - identification holds maker, model, serial and revision.
// - revision joins interface, measurement and source revisions.
// - recall takes slot 0 to 16; empty slot loads factory state.
// - slot 0 captures the instrument state at power down.
// - slots 1 to 16 start empty.
// - slot contents survive reset and preset until overwritten.
module seu_core #(
  parameter logic [15:0] MAKER_ID = 16'h0001, // arbitrary value
  parameter logic [15:0] MODEL_ID = 16'h0002, // arbitrary value
  parameter logic [31:0] SERIAL_ID = 32'h0000_0003, // arbitrary value
  parameter logic [15:0] REV_IFACE = 16'h0001, // arbitrary value
  parameter logic [15:0] REV_MEAS = 16'h0002, // arbitrary value
  parameter logic [15:0] REV_SOURCE = 16'h0003 // arbitrary value
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input seu_pkg::seu_req_t req_i,
  input wire logic [7:0] event_i,
  input wire logic op_busy_i,
  input wire logic power_up_i,
  input wire logic power_fail_i,
  input wire logic [`SEU_STATE_W-1:0] state_i,
  output seu_pkg::seu_resp_t resp_o,
  output seu_pkg::seu_idn_t idn_o,
  output seu_pkg::seu_load_t load_o,
  output logic [7:0] stb_o,
  output logic [7:0] event_latch_o,
  output logic err_queue_clear_o,
  output logic prot_clear_o
);
  import seu_pkg::*;

  typedef enum logic [0:0] {
    SEU_Q_IDLE = 1'b0,
    SEU_Q_WAIT = 1'b1
  } seu_qstate_t;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] standard_event_latch;
  logic [7:0] standard_event_enable_mask;
  logic psc_setting;
  logic opc_armed;
  seu_qstate_t qstate;
  seu_qstate_t next_qstate;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [`SEU_SLOTS-1:0] slot_valid;
  logic load_pend;
  logic load_hit;
  logic [`SEU_STATE_W-1:0] mem_rdata;

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  wire is_cls = req_i.valid && req_i.code == SEU_CLS;
  wire is_ese = req_i.valid && req_i.code == SEU_ESE;
  wire is_ese_q = req_i.valid && req_i.code == SEU_ESE_Q;
  wire is_esr_q = req_i.valid && req_i.code == SEU_ESR_Q;
  wire is_idn_q = req_i.valid && req_i.code == SEU_IDN_Q;
  wire is_opc = req_i.valid && req_i.code == SEU_OPC;
  wire is_opc_q = req_i.valid && req_i.code == SEU_OPC_Q;
  wire is_psc = req_i.valid && req_i.code == SEU_PSC;
  wire is_psc_q = req_i.valid && req_i.code == SEU_PSC_Q;
  wire is_rcl = req_i.valid && req_i.code == SEU_RCL;
  wire is_sav = req_i.valid && req_i.code == SEU_SAV;
  wire is_rst = req_i.valid && req_i.code == SEU_RST;

  // slot index checks
  wire slot_in_range = req_i.arg <= `SEU_SLOT_MAX;
  wire [`SEU_SLOT_W-1:0] slot_idx = req_i.arg[`SEU_SLOT_W-1:0];
  wire rcl_ok = is_rcl && slot_in_range;
  wire slot_bad = (is_rcl || is_sav) && !slot_in_range;
  wire sav_ok = is_sav && slot_in_range;

  // power pin edges, read only from the second stage onward
  wire pwr_up = pin_sync[0] && !pin_prev[0];
  wire pwr_fail = pin_sync[1] && !pin_prev[1];

  // ----------------------------------------------------------------------
  // event latch next value
  // ----------------------------------------------------------------------
  wire opc_fire = opc_armed && !op_busy_i;
  wire [7:0] ev_raise = {pwr_up, 2'b00, slot_bad, 3'b000, opc_fire};
  wire [7:0] ev_set = (event_i | ev_raise) & `SEU_EV_USED;
  // power-on clear of the latch ignores the setting
  wire ev_clear = is_cls || is_esr_q || pwr_up;
  // set wins over clear; a set bit simply stays set
  wire [7:0] next_latch = ev_set |
    (standard_event_latch & ~{8{ev_clear}});

  // status byte summary
  wire esb = |(standard_event_latch & standard_event_enable_mask);
  assign stb_o = 8'(esb) << `SEU_STB_ESB;
  assign event_latch_o = standard_event_latch;

  // ----------------------------------------------------------------------
  // opc query sequencing
  // ----------------------------------------------------------------------
  wire other_q = is_ese_q || is_esr_q || is_psc_q || is_idn_q;
  wire opc_done = qstate == SEU_Q_WAIT && !op_busy_i && !other_q;

  always_comb begin
    next_qstate = qstate;
    unique case (qstate)
      SEU_Q_IDLE: begin
        if (is_opc_q) begin
          next_qstate = SEU_Q_WAIT;
        end
      end
      SEU_Q_WAIT: begin
        if (opc_done || is_cls) begin
          next_qstate = SEU_Q_IDLE;
        end
      end
    endcase
  end

  // answer selection
  wire resp_fire = other_q || opc_done;
  wire [7:0] resp_value = is_ese_q ? standard_event_enable_mask :
    is_esr_q ? standard_event_latch :
    is_psc_q ? 8'(psc_setting) :
    opc_done ? `SEU_OPC_ONE : 8'h00;

  // ----------------------------------------------------------------------
  // slot memory access
  // ----------------------------------------------------------------------
  wire mem_we = pwr_fail || sav_ok;
  wire [`SEU_SLOT_W-1:0] mem_waddr = pwr_fail ? `SEU_SLOT_POWER : slot_idx;
  wire [`SEU_SLOTS-1:0] slot_set = `SEU_SLOTS'(mem_we) << mem_waddr;

  seu_slot_mem u_slot_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(state_i),
    .rd_addr_i(slot_idx),
    .rd_data_o(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // power pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {power_fail_i, power_up_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // event latch, power-on bit set from reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      standard_event_latch <= `SEU_EV_RESET;
    end else begin
      standard_event_latch <= next_latch;
    end
  end

  // enable mask: kept over clear status, zeroed at power-on if set so
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      standard_event_enable_mask <= `SEU_MASK_RESET;
    end else if (is_ese) begin
      standard_event_enable_mask <= req_i.arg;
    end else if (pwr_up && psc_setting) begin
      standard_event_enable_mask <= `SEU_MASK_RESET;
    end
  end

  // power-on clear setting
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      psc_setting <= `SEU_PSC_RESET;
    end else if (is_psc) begin
      psc_setting <= req_i.arg[0];
    end
  end

  // operation complete tracking
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      opc_armed <= 1'b0;
      qstate <= SEU_Q_IDLE;
    end else begin
      opc_armed <= is_opc || (opc_armed && op_busy_i && !is_cls);
      qstate <= next_qstate;
    end
  end

  // answers and clear pulses
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      resp_o <= '0;
      err_queue_clear_o <= 1'b0;
      prot_clear_o <= 1'b0;
    end else begin
      resp_o <= '{valid: resp_fire, value: resp_value};
      err_queue_clear_o <= is_cls;
      prot_clear_o <= is_cls;
    end
  end

  // identification fields, loaded on query
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      idn_o <= '0;
    end else if (is_idn_q) begin
      idn_o <= '{maker: MAKER_ID, model: MODEL_ID, serial: SERIAL_ID,
        rev_iface: REV_IFACE, rev_meas: REV_MEAS,
        rev_source: REV_SOURCE};
    end
  end

  // slot occupancy: empty from factory, untouched by reset command
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slot_valid <= '0;
    end else begin
      slot_valid <= slot_valid | slot_set;
    end
  end

  // state load: memory read lands one cycle later, output the next
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      load_pend <= 1'b0;
      load_hit <= 1'b0;
      load_o <= '0;
    end else begin
      load_pend <= rcl_ok || is_rst;
      load_hit <= rcl_ok && slot_valid[slot_idx];
      load_o.valid <= load_pend;
      if (load_pend) begin
        load_o.state <= load_hit ? mem_rdata : `SEU_FACTORY_STATE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  cls_clears_all_a: assert property (
    is_cls && ev_set == 8'h00 |=> standard_event_latch == 8'h00 &&
      err_queue_clear_o ##1 err_queue_clear_o == $past(is_cls))
    else $error("clear status left events or missed queue clear");

  cls_prot_a: assert property (
    is_cls |=> prot_clear_o)
    else $error("clear status did not drop protection trips");

  esb_report_a: assert property (
    $rose(standard_event_latch[`SEU_EV_EXEC]) &&
      standard_event_enable_mask[`SEU_EV_EXEC] |-> stb_o[`SEU_STB_ESB])
    else $error("enabled event not reported on status bit");

  unused_bits_a: assert property (
    standard_event_latch[1] == 1'b0 && standard_event_latch[6] == 1'b0)
    else $error("unused event bit set");

  ese_readback_a: assert property (
    is_ese ##1 is_ese_q |=> resp_o.valid &&
      resp_o.value == $past(req_i.arg, 2))
    else $error("mask query differs from written mask");

  mask_keep_a: assert property (
    is_cls && !is_ese && !pwr_up |=>
      $stable(standard_event_enable_mask))
    else $error("clear status changed the mask");

  event_hold_a: assert property (
    standard_event_latch[`SEU_EV_CMD] && !ev_clear |=>
      standard_event_latch[`SEU_EV_CMD])
    else $error("set event bit lost without clear");

  esr_read_a: assert property (
    is_esr_q && ev_set == 8'h00 |=> standard_event_latch == 8'h00 &&
      resp_o.value == $past(standard_event_latch))
    else $error("event query wrong or latch not cleared");

  opc_bit_a: assert property (
    is_opc ##1 (op_busy_i && !is_cls) [*2] ##1 !op_busy_i |=>
      standard_event_latch[`SEU_EV_OPC])
    else $error("opc bit not set at end of operation");

  opcq_wait_a: assert property (
    qstate == SEU_Q_WAIT && op_busy_i && !is_cls |=>
      qstate == SEU_Q_WAIT && !(resp_o.valid && !$past(other_q)))
    else $error("opc query answered while busy");

  psc_clear_a: assert property (
    pwr_up && psc_setting && !is_ese |=>
      standard_event_enable_mask == 8'h00)
    else $error("power-on did not clear mask");

  rcl_empty_a: assert property (
    rcl_ok && !slot_valid[slot_idx] |=> ##1 load_o.valid &&
      load_o.state == `SEU_FACTORY_STATE)
    else $error("empty slot did not load factory state");

  slot0_cap_a: assert property (
    pwr_fail |=> slot_valid[0])
    else $error("power down did not capture slot 0");

  esb_sum_a: assert property (
    stb_o[`SEU_STB_ESB] ==
      |(standard_event_latch & standard_event_enable_mask))
    else $error("status bit 5 differs from masked latch");

  // summary follows a fresh mask against the latch it meets
  esb_mask_a: assert property (
    is_ese && !ev_clear |=> stb_o[`SEU_STB_ESB] ==
      |($past(req_i.arg) & ($past(standard_event_latch) | $past(ev_set))))
    else $error("status bit 5 wrong after mask write");

  opc_seq_c: cover property (is_opc ##[1:20] opc_fire);
  rcl_hit_c: cover property (rcl_ok && slot_valid[slot_idx]);
  esb_rise_c: cover property ($rose(stb_o[`SEU_STB_ESB]));
  opcq_done_c: cover property (opc_done);

endmodule

/* File: testbench/seu_host.sv */
/*
  host model: issues one common command at a time and collects answers.
  assumes the unit takes a request at the edge where valid is high.
*/
`timescale 1ns/1ps

module seu_host (
  input wire logic clock_i,
  input seu_pkg::seu_resp_t resp_i,
  output seu_pkg::seu_req_t req_o
);
  import seu_pkg::*;

  initial req_o = '0;

  // ------------------
  // command issue
  // ------------------
  // one-cycle valid pulse; mask and slot go out unchecked, out-of-range slots too
  task automatic send(input seu_cmd_t c, input logic [7:0] a);
    @(posedge clock_i);
    req_o <= '{valid: 1'b1, code: c, arg: a};
    @(posedge clock_i);
    req_o <= '0;
  endtask

  // two commands on consecutive edges, no idle cycle between
  task automatic send2(input seu_cmd_t c0, input logic [7:0] a0,
                       input seu_cmd_t c1, input logic [7:0] a1);
    @(posedge clock_i);
    req_o <= '{valid: 1'b1, code: c0, arg: a0};
    @(posedge clock_i);
    req_o <= '{valid: 1'b1, code: c1, arg: a1};
    @(posedge clock_i);
    req_o <= '0;
  endtask

  // bounded wait for the answer pulse
  task automatic take(output logic [7:0] v, output bit ok);
    ok = 1'b0;
    v = 8'hxx;
    for (int i = 0; i < 40 && !ok; i++) begin
      #1;
      if (resp_i.valid === 1'b1) begin
        v = resp_i.value;
        ok = 1'b1;
      end else begin
        @(posedge clock_i);
      end
    end
  endtask
endmodule

/* File: testbench/tb.sv */
/*
  self-checking bench of the status unit: host model on the command port,
  bench drives events, busy, power pins and instrument state.
  assumes the unit and its package are compiled first.
*/
`timescale 1ns/1ps
`include "seu_defs.svh"

module tb;
  import seu_pkg::*;

  localparam logic [15:0] MK = 16'h00a1; // arbitrary value
  localparam logic [15:0] MD = 16'h00b2; // arbitrary value
  localparam logic [31:0] SN = 32'h0000_0c3d; // arbitrary value
  localparam logic [15:0] RI = 16'h0011; // arbitrary value
  localparam logic [15:0] RM = 16'h0022; // arbitrary value
  localparam logic [15:0] RS = 16'h0033; // arbitrary value

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  seu_req_t req;
  logic [7:0] event_i = 8'h00;
  logic op_busy_i = 1'b0;
  logic power_up_i = 1'b0;
  logic power_fail_i = 1'b0;
  logic [15:0] state_i = 16'h0000;
  seu_resp_t resp_o;
  seu_idn_t idn_o;
  seu_load_t load_o;
  logic [7:0] stb_o;
  logic [7:0] event_latch_o;
  logic err_queue_clear_o;
  logic prot_clear_o;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_55f5;

  // ------------------
  // clock and parts
  // ------------------
  always #4 clock_i = ~clock_i;

  seu_host host (.clock_i(clock_i), .resp_i(resp_o), .req_o(req));

  seu_core #(.MAKER_ID(MK), .MODEL_ID(MD), .SERIAL_ID(SN),
    .REV_IFACE(RI), .REV_MEAS(RM), .REV_SOURCE(RS)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .req_i(req), .event_i(event_i),
    .op_busy_i(op_busy_i), .power_up_i(power_up_i),
    .power_fail_i(power_fail_i), .state_i(state_i), .resp_o(resp_o),
    .idn_o(idn_o), .load_o(load_o), .stb_o(stb_o),
    .event_latch_o(event_latch_o), .err_queue_clear_o(err_queue_clear_o),
    .prot_clear_o(prot_clear_o));

  // ------------------
  // helpers
  // ------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // status byte expected from latch and mask
  function automatic logic [7:0] exp_stb(input logic [7:0] l,
                                         input logic [7:0] m);
    exp_stb = 8'h00;
    exp_stb[`SEU_STB_ESB] = |(l & m);
  endfunction

  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    end_of_test();
  endtask

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic ask(input seu_cmd_t c, input logic [7:0] a,
                     output logic [7:0] v);
    bit ok;
    host.send(c, a);
    host.take(v, ok);
    if (!ok) timeout();
  endtask

  // command that ends in a state load
  task automatic loadwait(input seu_cmd_t c, input logic [7:0] a,
                          output logic [15:0] s);
    host.send(c, a);
    for (int i = 0; i < 8; i++) begin
      #1;
      if (load_o.valid === 1'b1) begin
        s = load_o.state;
        return;
      end
      @(posedge clock_i);
    end
    timeout();
  endtask

  task automatic pulse(input logic [7:0] ev);
    @(posedge clock_i);
    event_i <= ev;
    @(posedge clock_i);
    event_i <= 8'h00;
    #1;
  endtask

  // long enough for the pin synchroniser and edge detect
  task automatic power_pin(input bit fail);
    @(posedge clock_i);
    power_fail_i <= fail;
    power_up_i <= !fail;
    repeat (6) @(posedge clock_i);
    power_fail_i <= 1'b0;
    power_up_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  // ------------------
  // main sequence
  // ------------------
  initial begin
    logic [7:0] v;
    logic [7:0] m;
    logic [7:0] ev;
    logic [15:0] s;
    logic [15:0] st;
    bit ok;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    check(event_latch_o, `SEU_EV_RESET);
    check(stb_o, 8'h00);
    ask(SEU_ESE_Q, 8'h00, v);
    check(v, `SEU_MASK_RESET);
    ask(SEU_PSC_Q, 8'h00, v);
    check(v, 8'h01);
    ask(SEU_ESR_Q, 8'h00, v);
    check(v, 8'h80);
    check(event_latch_o, 8'h00);
    // random masks and events, all-ones corner first
    for (int k = 0; k < 24; k++) begin
      m = k == 0 ? 8'hff : 8'(rnd());
      ev = k == 0 ? 8'hff : 8'(rnd());
      host.send2(SEU_ESE, m, SEU_ESE_Q, 8'h00);
      host.take(v, ok);
      if (!ok) timeout();
      check(v, m);
      pulse(ev);
      check(event_latch_o, ev & `SEU_EV_USED);
      check(stb_o, exp_stb(ev & `SEU_EV_USED, m));
      pulse(ev);
      ask(SEU_ESR_Q, 8'h00, v);
      check(v, ev & `SEU_EV_USED);
      check(stb_o, 8'h00);
    end
    // clear status keeps the mask
    host.send(SEU_ESE, 8'hff);
    pulse(8'h3c);
    host.send(SEU_CLS, 8'h00);
    #1;
    check(err_queue_clear_o, 1'b1);
    check(prot_clear_o, 1'b1);
    check(event_latch_o, 8'h00);
    ask(SEU_ESE_Q, 8'h00, v);
    check(v, 8'hff);
    // operation complete waits for busy to drop
    @(posedge clock_i);
    op_busy_i <= 1'b1;
    host.send(SEU_OPC, 8'h00);
    repeat (1) @(posedge clock_i);
    #1;
    check(event_latch_o, 8'h00);
    @(posedge clock_i);
    op_busy_i <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(posedge clock_i);
      #1;
      ok = event_latch_o[0] === 1'b1;
    end
    if (!ok) timeout();
    check(event_latch_o, 8'h01);
    ask(SEU_ESR_Q, 8'h00, v);
    @(posedge clock_i);
    op_busy_i <= 1'b1;
    host.send(SEU_OPC_Q, 8'h00);
    repeat (4) begin
      #1;
      check(resp_o.valid, 1'b0);
      @(posedge clock_i);
    end
    op_busy_i <= 1'b0;
    host.take(v, ok);
    if (!ok) timeout();
    check(v, `SEU_OPC_ONE);
    // power-on clear setting off, then on
    host.send(SEU_ESE, 8'h24);
    host.send(SEU_PSC, 8'h00);
    power_pin(1'b0);
    ask(SEU_ESE_Q, 8'h00, v);
    check(v, 8'h24);
    ask(SEU_PSC_Q, 8'h00, v);
    check(v, 8'h00);
    check(event_latch_o, 8'h80);
    host.send(SEU_PSC, 8'h01);
    power_pin(1'b0);
    ask(SEU_ESE_Q, 8'h00, v);
    check(v, 8'h00);
    ask(SEU_ESR_Q, 8'h00, v);
    check(v, 8'h80);
    ask(SEU_IDN_Q, 8'h00, v);
    check(idn_o, {MK, MD, SN, RI, RM, RS});
    // slots: empty, save, reset, power down, out of range
    for (int k = 1; k <= 16; k++) begin
      loadwait(SEU_RCL, 8'(k), s);
      check(s, `SEU_FACTORY_STATE);
    end
    st = 16'(rnd());
    @(posedge clock_i);
    state_i <= st;
    host.send(SEU_SAV, `SEU_SLOT_MAX);
    loadwait(SEU_RST, 8'h00, s);
    check(s, `SEU_FACTORY_STATE);
    loadwait(SEU_RCL, `SEU_SLOT_MAX, s);
    check(s, st);
    st = ~st;
    @(posedge clock_i);
    state_i <= st;
    power_pin(1'b1);
    loadwait(SEU_RCL, 8'h00, s);
    check(s, st);
    host.send(SEU_RCL, 8'h11);
    @(posedge clock_i);
    #1;
    check(event_latch_o, 8'h10);
    end_of_test();
  end
endmodule
